// File: fga_pkg.sv
// Purpose: shared constants and types of the flash region access guard
// Assumes: 32-bit descriptor words, 25-bit flash byte addresses, 4 KB pages
// Notes:   both ends and the region matcher use these names
package fga_pkg;
	// ----------------------------------------------------------------
	// descriptor field layout
	// ----------------------------------------------------------------
	localparam int DATA_W     = 32;
	localparam int FADDR_W    = 25;
	localparam int ID_W       = 16;
	localparam int PAGE_LSB   = 12;
	localparam int PAGE_W     = 13;
	localparam int LIMIT_LSB  = 16;
	localparam int BASE_LSB   = 0;
	localparam int WR_LSB     = 24;
	localparam int RD_LSB     = 16;
	localparam int ID_LSB     = 0;
	localparam int NR_LSB     = 24;
	localparam int NR_W       = 3;
	localparam int NREGIONS   = 4;
	localparam int NMASTERS   = 3;
	localparam int IDX_W      = 2;

	localparam logic [DATA_W-1:0] REGION_UNUSED    = 32'h0000_0FFF;
	localparam logic [DATA_W-1:0] REGION0_RESET    = 32'h0000_0000;
	localparam logic [DATA_W-1:0] MASTER_HOST_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] MASTER_ENG_RST   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] MASTER_LAN_RST   = 32'h0000_0218;
	localparam logic [DATA_W-1:0] MASTER_RSVD_MASK = 32'hF0F0_0000;
	localparam logic [NR_W-1:0]   NR_RESET         = 3'h0;

	// lan region span limit, in pages
	localparam int LAN_MAX_SPAN_KB = 128;
	localparam int PAGE_KB         = 4;
	localparam logic [PAGE_W-1:0] LAN_MAX_SPAN =
		PAGE_W'(LAN_MAX_SPAN_KB / PAGE_KB);
	localparam logic [IDX_W-1:0]  LAN_REGION   = 2'h3;

	typedef enum logic [1:0] {SECT_REGION, SECT_MASTER, SECT_COUNT} fga_sect_t;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} fga_op_t;

	// ----------------------------------------------------------------
	// controller register map (axi4-lite, byte addresses)
	// ----------------------------------------------------------------
	localparam int AXI_ADDR_W = 8;
	localparam logic [AXI_ADDR_W-1:0] OFS_DESC_DATA = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_DESC_CMD  = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFS_REQ_ADDR  = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFS_REQ_CMD   = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] OFS_STATUS    = 8'h10;
	localparam int CMD_SECT_LSB = 0;
	localparam int CMD_IDX_LSB  = 4;
	localparam int REQ_ID_LSB   = 0;
	localparam int REQ_OP_LSB   = 16;
	localparam int REQ_ENG_BIT  = 18;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_DONE    = 1;
	localparam int STAT_ERR     = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// File: fga_link_if.sv
// Purpose: link between the controller end and the guard end
// Assumes: both ends on aclk
// Notes:   cfg is a one-cycle load pulse; req is valid/ready; rsp is a pulse
`timescale 1ns/1ns
interface fga_link_if;
	logic                          cfg_valid;
	fga_pkg::fga_sect_t            cfg_sect;
	logic [fga_pkg::IDX_W-1:0]     cfg_index;
	logic [fga_pkg::DATA_W-1:0]    cfg_data;
	logic                          req_valid;
	logic                          req_ready;
	logic [fga_pkg::ID_W-1:0]      req_id;
	logic [fga_pkg::FADDR_W-1:0]   req_addr;
	fga_pkg::fga_op_t              req_op;
	logic                          req_engine;
	logic                          rsp_valid;
	logic                          rsp_error;

	modport dev (input cfg_valid, cfg_sect, cfg_index, cfg_data,
		input req_valid, req_id, req_addr, req_op, req_engine,
		output req_ready, rsp_valid, rsp_error);
	modport ctl (output cfg_valid, cfg_sect, cfg_index, cfg_data,
		output req_valid, req_id, req_addr, req_op, req_engine,
		input req_ready, rsp_valid, rsp_error);
endinterface

// File: fga_region_match.sv
// Purpose: decides whether a flash page lies inside one region window
// Assumes: entry holds limit and base page fields
// Notes:   purely combinational
`timescale 1ns/1ns
module fga_region_match (
	input  wire logic [fga_pkg::DATA_W-1:0] entry,
	input  wire logic [fga_pkg::PAGE_W-1:0] page,
	output logic                            hit
);
	logic [fga_pkg::PAGE_W-1:0] base;
	logic [fga_pkg::PAGE_W-1:0] limit;

	assign limit = entry[fga_pkg::LIMIT_LSB +: fga_pkg::PAGE_W];
	assign base  = entry[fga_pkg::BASE_LSB +: fga_pkg::PAGE_W];
	// a base above the limit can never hit, which disables the region
	assign hit = (page >= base) && (page <= limit);
endmodule

// File: fga_guard.sv
// Purpose: guards flash requests with descriptor region and master entries
// Assumes: entries arrive over the link from the controller end
// Notes:   one request in flight; answer two cycles after it is taken
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns

// Functional notes
// - limit field 28:16 is upper page
// - base field 12:0 is lower page
// - four region entries at word offsets
// - unused region base FFFh limit 000h
// - lan limit within 128 KB of base
// - three master entries at word offsets
// - write or erase needs region write bit
// - read needs region read bit
// - own primary region always granted
// - master reserved bits written as zero
// - host requester id 0000h identifies host
// - engine requester id is 0000h
// - lan requester id 0218h identifies lan
// - regions beyond count default FFFh/000h
module fga_guard (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         ce,
	fga_link_if.dev                           lnk,
	output logic                              flash_go_ff,
	output fga_pkg::fga_op_t                  flash_op_ff,
	output logic [fga_pkg::FADDR_W-1:0]       flash_addr_ff,
	output logic                              access_error_ff,
	output logic [fga_pkg::IDX_W-1:0]         last_region_ff
);
	typedef enum logic {ST_IDLE, ST_CHECK} fga_state_t;
	localparam logic [fga_pkg::IDX_W-1:0] M_HOST = 2'h0;
	localparam logic [fga_pkg::IDX_W-1:0] M_ENG  = 2'h1;
	localparam logic [fga_pkg::IDX_W-1:0] M_LAN  = 2'h2;
	localparam logic [fga_pkg::IDX_W-1:0] M_NONE = 2'h3;

	logic [fga_pkg::DATA_W-1:0]  region_ff [fga_pkg::NREGIONS];
	logic [fga_pkg::DATA_W-1:0]  master_ff [fga_pkg::NMASTERS];
	logic [fga_pkg::NR_W-1:0]    nr_ff;
	fga_state_t                  state_ff;
	logic                        req_ready_ff;
	logic                        rsp_valid_ff;
	logic                        rsp_error_ff;
	logic [fga_pkg::ID_W-1:0]    id_ff;
	logic [fga_pkg::FADDR_W-1:0] addr_ff;
	fga_pkg::fga_op_t            op_ff;
	logic                        engine_ff;
	logic [fga_pkg::NR_W-1:0]    nxt_nr;
	logic [fga_pkg::NREGIONS-1:0] hit;
	logic                        hit_any;
	logic [fga_pkg::IDX_W-1:0]   hit_idx;
	logic [fga_pkg::IDX_W-1:0]   msel;
	logic                        perm;
	logic                        allowed;

	assign lnk.req_ready = req_ready_ff;
	assign lnk.rsp_valid = rsp_valid_ff;
	assign lnk.rsp_error = rsp_error_ff;
	assign nxt_nr = lnk.cfg_data[fga_pkg::NR_LSB +: fga_pkg::NR_W];

	// ----------------------------------------------------------------
	// descriptor entries
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// until a count arrives only region 0 is in use
			region_ff[0] <= fga_pkg::REGION0_RESET;
			for (int i = 1; i < fga_pkg::NREGIONS; i++) begin
				region_ff[i] <= fga_pkg::REGION_UNUSED;
			end
		end else if (ce && lnk.cfg_valid) begin
			if (lnk.cfg_sect == fga_pkg::SECT_REGION) begin
				// entry index is the command index field; entries past the count keep defaults
				if (lnk.cfg_index <= IDX_W_NR(nr_ff)) begin
					region_ff[lnk.cfg_index] <= lnk.cfg_data;
				end
			end else if (lnk.cfg_sect == fga_pkg::SECT_COUNT) begin
				for (int i = 1; i < fga_pkg::NREGIONS; i++) begin
					if (fga_pkg::NR_W'(i) > nxt_nr) begin
						region_ff[i] <= fga_pkg::REGION_UNUSED;
					end
				end
			end
		end
	end

	function automatic logic [fga_pkg::IDX_W-1:0] IDX_W_NR(
		input logic [fga_pkg::NR_W-1:0] nr
	);
		// counts above the last region saturate at region 3
		if (nr >= fga_pkg::NR_W'(fga_pkg::NREGIONS - 1)) begin
			return fga_pkg::IDX_W'(fga_pkg::NREGIONS - 1);
		end
		return nr[fga_pkg::IDX_W-1:0];
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nr_ff <= fga_pkg::NR_RESET;
		end else if (ce && lnk.cfg_valid && lnk.cfg_sect == fga_pkg::SECT_COUNT) begin
			nr_ff <= nxt_nr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// id fields start at the values each requester must carry
			master_ff[M_HOST] <= fga_pkg::MASTER_HOST_RST;
			master_ff[M_ENG]  <= fga_pkg::MASTER_ENG_RST;
			master_ff[M_LAN]  <= fga_pkg::MASTER_LAN_RST;
		end else if (ce && lnk.cfg_valid && lnk.cfg_sect == fga_pkg::SECT_MASTER) begin
			if (lnk.cfg_index < fga_pkg::IDX_W'(fga_pkg::NMASTERS)) begin
				master_ff[lnk.cfg_index] <= lnk.cfg_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// region and master decode
	// ----------------------------------------------------------------
	for (genvar g = 0; g < fga_pkg::NREGIONS; g++) begin : g_match
		fga_region_match u_match (
			.entry (region_ff[g]),
			.page  (addr_ff[fga_pkg::PAGE_LSB +: fga_pkg::PAGE_W]),
			.hit   (hit[g])
		);
	end

	always_comb begin
		hit_any = 1'b0;
		hit_idx = '0;
		// lowest region wins where windows overlap
		for (int i = fga_pkg::NREGIONS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hit_any = 1'b1;
				hit_idx = fga_pkg::IDX_W'(i);
			end
		end
	end

	always_comb begin
		// both host and engine ids are zero, so the engine path flag comes first
		if (engine_ff) begin
			msel = M_ENG;
		end else if (id_ff == master_ff[M_LAN][fga_pkg::ID_LSB +: fga_pkg::ID_W]) begin
			msel = M_LAN;
		end else if (id_ff == master_ff[M_HOST][fga_pkg::ID_LSB +: fga_pkg::ID_W]) begin
			msel = M_HOST;
		end else begin
			msel = M_NONE;
		end
	end

	always_comb begin
		perm = 1'b0;
		if (msel != M_NONE) begin
			if (op_ff == fga_pkg::OP_READ) begin
				perm = master_ff[msel][fga_pkg::RD_LSB + int'(hit_idx)];
			end else begin
				perm = master_ff[msel][fga_pkg::WR_LSB + int'(hit_idx)];
			end
		end
		// master n owns region n+1 and ignores its own bits there
		allowed = hit_any && (msel != M_NONE)
			&& ((hit_idx == msel + 2'h1) || perm);
	end

	// ----------------------------------------------------------------
	// request handling
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff     <= ST_IDLE;
			req_ready_ff <= 1'b1;
			rsp_valid_ff <= 1'b0;
			rsp_error_ff <= 1'b0;
		end else if (ce) begin
			unique case (state_ff)
				ST_IDLE: begin
					rsp_valid_ff <= 1'b0;
					if (lnk.req_valid) begin
						req_ready_ff <= 1'b0;
						state_ff     <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					rsp_valid_ff <= 1'b1;
					rsp_error_ff <= !allowed;
					req_ready_ff <= 1'b1;
					state_ff     <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			id_ff     <= '0;
			addr_ff   <= '0;
			op_ff     <= fga_pkg::OP_READ;
			engine_ff <= 1'b0;
		end else if (ce && state_ff == ST_IDLE && lnk.req_valid) begin
			id_ff     <= lnk.req_id;
			addr_ff   <= lnk.req_addr;
			op_ff     <= lnk.req_op;
			engine_ff <= lnk.req_engine;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_go_ff     <= 1'b0;
			flash_op_ff     <= fga_pkg::OP_READ;
			flash_addr_ff   <= '0;
			access_error_ff <= 1'b0;
			last_region_ff  <= '0;
		end else if (ce) begin
			// a denied access never reaches the flash side
			flash_go_ff     <= (state_ff == ST_CHECK) && allowed;
			access_error_ff <= (state_ff == ST_CHECK) && !allowed;
			if (state_ff == ST_CHECK) begin
				flash_op_ff    <= op_ff;
				flash_addr_ff  <= addr_ff;
				last_region_ff <= hit_idx;
			end
		end
	end
endmodule

// File: fga_ctrl.sv
// Purpose: axi4-lite front end that loads descriptor entries and issues requests
// Assumes: software writes the count, then regions, then masters
// Notes:   one request at a time; status shows busy, done and error
`timescale 1ns/1ns
module fga_ctrl (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           ce,
	fga_link_if.ctl                             lnk,
	input  wire logic [fga_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [fga_pkg::DATA_W-1:0]     s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [fga_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [fga_pkg::DATA_W-1:0]          s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready
);
	logic [fga_pkg::AXI_ADDR_W-1:0] awaddr_ff;
	logic [fga_pkg::DATA_W-1:0]     wdata_ff;
	logic [3:0]                     wstrb_ff;
	logic                           do_wr;
	logic [fga_pkg::DATA_W-1:0]     desc_ff;
	logic [fga_pkg::DATA_W-1:0]     cmd_ff;
	logic                           busy_ff;
	logic                           done_ff;
	logic                           err_ff;
	logic [fga_pkg::PAGE_W-1:0]     span;
	logic                           lan_bad;
	logic                           cmd_wr;
	logic                           req_wr;
	logic [fga_pkg::DATA_W-1:0]     merged;
	logic [fga_pkg::DATA_W-1:0]     merge_old;

	// ----------------------------------------------------------------
	// axi4-lite write path
	// ----------------------------------------------------------------
	assign do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign span   = desc_ff[fga_pkg::LIMIT_LSB +: fga_pkg::PAGE_W]
		- desc_ff[fga_pkg::BASE_LSB +: fga_pkg::PAGE_W];
	// lan entry whose limit reaches past the allowed span is refused
	assign lan_bad = wdata_ff[fga_pkg::CMD_SECT_LSB +: 2] == fga_pkg::SECT_REGION
		&& wdata_ff[fga_pkg::CMD_IDX_LSB +: fga_pkg::IDX_W] == fga_pkg::LAN_REGION
		&& desc_ff[fga_pkg::LIMIT_LSB +: fga_pkg::PAGE_W]
		>= desc_ff[fga_pkg::BASE_LSB +: fga_pkg::PAGE_W]
		&& span > fga_pkg::LAN_MAX_SPAN;
	assign cmd_wr = do_wr && awaddr_ff == fga_pkg::OFS_DESC_CMD && !lan_bad;
	assign req_wr = do_wr && awaddr_ff == fga_pkg::OFS_REQ_CMD && !busy_ff;
	assign merge_old = (awaddr_ff == fga_pkg::OFS_REQ_ADDR) ? fga_pkg::DATA_W'(lnk.req_addr)
		: desc_ff;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			merged[b*8 +: 8] = wstrb_ff[b] ? wdata_ff[b*8 +: 8] : merge_old[b*8 +: 8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= fga_pkg::RESP_OKAY;
			awaddr_ff     <= '0;
			wdata_ff      <= '0;
			wstrb_ff      <= '0;
		end else if (ce) begin
			if (s_axi_awready && s_axi_awvalid) begin
				awaddr_ff     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				unique case (awaddr_ff)
					fga_pkg::OFS_DESC_DATA, fga_pkg::OFS_REQ_ADDR:
						s_axi_bresp <= fga_pkg::RESP_OKAY;
					fga_pkg::OFS_DESC_CMD:
						s_axi_bresp <= lan_bad ? fga_pkg::RESP_SLVERR : fga_pkg::RESP_OKAY;
					fga_pkg::OFS_REQ_CMD:
						s_axi_bresp <= busy_ff ? fga_pkg::RESP_SLVERR : fga_pkg::RESP_OKAY;
					default:
						s_axi_bresp <= fga_pkg::RESP_DECERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// descriptor loading and requests
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			desc_ff       <= '0;
			lnk.cfg_valid <= 1'b0;
			lnk.cfg_sect  <= fga_pkg::SECT_REGION;
			lnk.cfg_index <= '0;
			lnk.cfg_data  <= '0;
		end else if (ce) begin
			if (do_wr && awaddr_ff == fga_pkg::OFS_DESC_DATA) begin
				desc_ff <= merged;
			end
			lnk.cfg_valid <= cmd_wr;
			if (cmd_wr) begin
				lnk.cfg_sect  <= fga_pkg::fga_sect_t'(wdata_ff[fga_pkg::CMD_SECT_LSB +: 2]);
				lnk.cfg_index <= wdata_ff[fga_pkg::CMD_IDX_LSB +: fga_pkg::IDX_W];
				// master entries leave with their reserved bits cleared
				lnk.cfg_data  <= (wdata_ff[fga_pkg::CMD_SECT_LSB +: 2] == fga_pkg::SECT_MASTER)
					? (desc_ff & ~fga_pkg::MASTER_RSVD_MASK) : desc_ff;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ff         <= '0;
			lnk.req_addr   <= '0;
			lnk.req_valid  <= 1'b0;
			lnk.req_id     <= '0;
			lnk.req_op     <= fga_pkg::OP_READ;
			lnk.req_engine <= 1'b0;
			busy_ff        <= 1'b0;
			done_ff        <= 1'b0;
			err_ff         <= 1'b0;
		end else if (ce) begin
			if (do_wr && awaddr_ff == fga_pkg::OFS_REQ_ADDR) begin
				lnk.req_addr <= merged[fga_pkg::FADDR_W-1:0];
			end
			if (req_wr) begin
				cmd_ff         <= wdata_ff;
				lnk.req_valid  <= 1'b1;
				lnk.req_id     <= wdata_ff[fga_pkg::REQ_ID_LSB +: fga_pkg::ID_W];
				lnk.req_op     <= fga_pkg::fga_op_t'(wdata_ff[fga_pkg::REQ_OP_LSB +: 2]);
				lnk.req_engine <= wdata_ff[fga_pkg::REQ_ENG_BIT];
				busy_ff        <= 1'b1;
				done_ff        <= 1'b0;
			end else if (lnk.req_valid && lnk.req_ready) begin
				lnk.req_valid <= 1'b0;
			end
			if (busy_ff && lnk.rsp_valid) begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
				err_ff  <= lnk.rsp_error;
			end
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read path
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= fga_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= fga_pkg::RESP_OKAY;
				s_axi_rdata   <= '0;
				unique case (s_axi_araddr)
					fga_pkg::OFS_DESC_DATA: s_axi_rdata <= desc_ff;
					fga_pkg::OFS_DESC_CMD:  s_axi_rdata <= '0;
					fga_pkg::OFS_REQ_ADDR:  s_axi_rdata <= fga_pkg::DATA_W'(lnk.req_addr);
					fga_pkg::OFS_REQ_CMD:   s_axi_rdata <= cmd_ff;
					fga_pkg::OFS_STATUS: begin
						s_axi_rdata[fga_pkg::STAT_BUSY] <= busy_ff;
						s_axi_rdata[fga_pkg::STAT_DONE] <= done_ff;
						s_axi_rdata[fga_pkg::STAT_ERR]  <= err_ff;
					end
					default: s_axi_rresp <= fga_pkg::RESP_DECERR;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// File: fga_checker.sv
// Purpose: link and guard output checks for the flash region access guard
// Assumes: both ends on aclk with ce held high
// Notes:   sits beside the link, sees plain signals only
`timescale 1ns/1ns
module fga_checker (
	input wire logic                         aclk,
	input wire logic                         aresetn,
	input wire logic                         cfg_valid,
	input wire fga_pkg::fga_sect_t           cfg_sect,
	input wire logic [fga_pkg::IDX_W-1:0]    cfg_index,
	input wire logic [fga_pkg::DATA_W-1:0]   cfg_data,
	input wire logic                         req_valid,
	input wire logic                         req_ready,
	input wire logic [fga_pkg::FADDR_W-1:0]  req_addr,
	input wire fga_pkg::fga_op_t             req_op,
	input wire logic                         rsp_valid,
	input wire logic                         rsp_error,
	input wire logic                         flash_go_ff,
	input wire fga_pkg::fga_op_t             flash_op_ff,
	input wire logic [fga_pkg::FADDR_W-1:0]  flash_addr_ff,
	input wire logic                         access_error_ff
);
	// ----------------------------------------------------------------
	// link and outcome rules
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_take; req_valid && req_ready; endsequence
	sequence s_ok; rsp_valid && !rsp_error; endsequence
	sequence s_deny; rsp_valid && rsp_error; endsequence
	a_rsp_after_take: assert property (s_take |=> ##1 rsp_valid)
		else $error("no answer after take");
	a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid && req_ready, 2))
		else $error("answer without a taken request");
	a_go_after_ok: assert property (s_ok |-> flash_go_ff && !access_error_ff)
		else $error("granted access not sent to flash");
	a_err_after_deny: assert property (s_deny |-> access_error_ff && !flash_go_ff)
		else $error("denied access not blocked and flagged");
	a_out_has_cause: assert property ((flash_go_ff || access_error_ff) |-> rsp_valid)
		else $error("flash pulse without an answer");
	a_addr_carried: assert property (flash_go_ff |-> flash_addr_ff == $past(req_addr, 2)
		&& flash_op_ff == $past(req_op, 2)) else $error("flash address or op wrong");
	a_rsvd_cleared: assert property (cfg_valid && cfg_sect == fga_pkg::SECT_MASTER
		|-> (cfg_data & fga_pkg::MASTER_RSVD_MASK) == 32'h0) else $error("reserved bits sent");
	a_lan_span: assert property (cfg_valid && cfg_sect == fga_pkg::SECT_REGION
		&& cfg_index == 2'h3 && cfg_data[12:0] <= cfg_data[28:16]
		|-> cfg_data[28:16] - cfg_data[12:0] <= 13'h020) else $error("lan span too wide");
	a_cfg_pulse: assert property (cfg_valid |=> !cfg_valid)
		else $error("cfg load longer than one cycle");
endmodule

// File: flash_region_access_guard_tb.sv
// Purpose: drives the controller over axi4-lite and judges guard decisions
// Assumes: fixed seed, region layout chosen here, masters random
// Notes:   expected decisions come from a local model of the descriptor
`timescale 1ns/1ns
module flash_region_access_guard_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rdat;
	logic        awready, wready, bvalid, arready, rvalid, go, aerr;
	logic [1:0]  bresp, rresp, resp, lreg;
	logic [31:0] rg [4];
	logic [31:0] ms [3];
	logic [24:0] fadr;
	fga_pkg::fga_op_t fop;
	int          fail_count = 0, num_checks = 0, seed = 90424, nr = 0, xr = 0;
	fga_link_if lnk ();
	fga_ctrl fga_ctrl_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .lnk(lnk.ctl),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fga_guard fga_guard_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .lnk(lnk.dev),
		.flash_go_ff(go), .flash_op_ff(fop), .flash_addr_ff(fadr), .access_error_ff(aerr),
		.last_region_ff(lreg));
	fga_checker fga_checker_i (.aclk(aclk), .aresetn(aresetn), .cfg_valid(lnk.cfg_valid),
		.cfg_sect(lnk.cfg_sect), .cfg_index(lnk.cfg_index), .cfg_data(lnk.cfg_data),
		.req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_addr(lnk.req_addr),
		.req_op(lnk.req_op), .rsp_valid(lnk.rsp_valid), .rsp_error(lnk.rsp_error),
		.flash_go_ff(go), .flash_op_ff(fop), .flash_addr_ff(fadr), .access_error_ff(aerr));
	// ----------------------------------------------------------------
	// bus tasks and model
	// ----------------------------------------------------------------
	always #10 aclk = ~aclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// disabled regions fail the inclusive test since base sits above limit
	function automatic logic exp_err(input logic [24:0] a, input logic [1:0] op,
			input logic [15:0] id, input logic eng);
		int r;
		int m;
		r = -1;
		for (int i = 3; i >= 0; i--)
			if (a[24:12] >= rg[i][12:0] && a[24:12] <= rg[i][28:16]) r = i;
		m = eng ? 1 : (id == ms[2][15:0]) ? 2 : (id == ms[0][15:0]) ? 0 : -1;
		xr = (r < 0) ? 0 : r;
		if (r < 0 || m < 0) return 1'b1;
		if (r == m + 1) return 1'b0;
		return !ms[m][((op == 2'h0) ? 16 : 24) + r];
	endfunction
	task automatic put(input logic [1:0] s, input logic [1:0] i, input logic [31:0] d,
			input logic [1:0] er);
		wr(fga_pkg::OFS_DESC_DATA, d);
		wr(fga_pkg::OFS_DESC_CMD, {26'h0, i, 2'h0, s});
		check(32'(resp), 32'(er));
		if (er == fga_pkg::RESP_OKAY) begin
			if (s == 2'h2) nr = (d[26:24] > 3'h3) ? 3 : int'(d[26:24]);
			for (int k = nr + 1; k < 4; k++) rg[k] = fga_pkg::REGION_UNUSED;
			if (s == 2'h0 && i <= nr) rg[i] = d;
			if (s == 2'h1 && i < 2'h3) ms[i] = d & ~fga_pkg::MASTER_RSVD_MASK;
		end
	endtask
	task automatic req(input logic [24:0] a, input logic [1:0] op, input logic [15:0] id,
			input logic eng);
		wr(fga_pkg::OFS_REQ_ADDR, {7'h0, a});
		wr(fga_pkg::OFS_REQ_CMD, {13'h0, eng, op, id});
		do rd(fga_pkg::OFS_STATUS); while (rdat[fga_pkg::STAT_DONE] !== 1'b1);
		check(rdat & 32'h7, {29'h0, exp_err(a, op, id, eng), 2'h2});
		check(32'(lreg), 32'(xr));
	endtask
	// region edges, each master, each op: read, write, erase
	task automatic sweep;
		logic [12:0] pg [4] = '{13'h003F, 13'h0040, 13'h00A0, 13'h00A1};
		for (int p = 0; p < 4; p++)
			for (int m = 0; m < 9; m++)
				req({pg[p], 12'hFFF}, 2'(m % 3), (m / 3 == 2) ? 16'h0218 : 16'h0000, m / 3 == 1);
	endtask
	task automatic burst(input int n);
		logic [31:0] r;
		for (int k = 0; k < n; k++) begin
			r = $random(seed);
			req({5'h0, 8'(r[7:0] % 8'hC0), r[19:8]}, 2'(r[21:20] % 2'h3),
				r[23] ? r[15:0] : (r[22] ? 16'h0218 : 16'h0000), r[24]);
		end
	endtask
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge aclk);
		fail_count++;
		end_sim();
	end
	initial begin
		rg = '{32'h0, fga_pkg::REGION_UNUSED, fga_pkg::REGION_UNUSED, fga_pkg::REGION_UNUSED};
		ms = '{32'h0, 32'h0, 32'h218};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		sweep();
		$display("test reset_defaults done");
		put(2'h2, 2'h0, 32'h0300_0000, fga_pkg::RESP_OKAY);
		put(2'h0, 2'h0, 32'h0000_0000, fga_pkg::RESP_OKAY);
		put(2'h0, 2'h1, 32'h003F_0001, fga_pkg::RESP_OKAY);
		put(2'h0, 2'h2, 32'h007F_0040, fga_pkg::RESP_OKAY);
		put(2'h0, 2'h3, 32'h00A1_0080, fga_pkg::RESP_SLVERR);
		put(2'h0, 2'h3, 32'h00A0_0080, fga_pkg::RESP_OKAY);
		for (int i = 0; i < 3; i++)
			put(2'h1, 2'(i), {16'($random(seed)), (i == 2) ? 16'h0218 : 16'h0000}, 2'h0);
		sweep();
		burst(60);
		put(2'h0, 2'h3, 32'h0000_0FFF, fga_pkg::RESP_OKAY);
		$display("test full_layout done");
		wr(8'h40, 32'h1);
		check(32'(resp), 32'(fga_pkg::RESP_DECERR));
		rd(8'h40);
		check({rdat[29:0], resp}, {30'h0, fga_pkg::RESP_DECERR});
		$display("test unmapped done");
		put(2'h2, 2'h0, 32'h0100_0000, fga_pkg::RESP_OKAY);
		sweep();
		burst(20);
		$display("test short_count done");
		end_sim();
	end
endmodule
